// File: core/lmfc_align_pkg.sv
// Constants and types for the frame-clock alignment block
package lmfc_align_pkg;

  // ==========================================================================
  // Register map (byte offsets on the serial-port register space)
  localparam logic [7:0] OFS_ERR_WINDOW  = 8'h34;
  localparam logic [7:0] OFS_LAST_ERR_L  = 8'h38;
  localparam logic [7:0] OFS_LAST_ERR_H  = 8'h39;
  localparam logic [7:0] OFS_SYNC_CTRL   = 8'h3A;
  localparam logic [7:0] OFS_SYNC_STATUS = 8'h3B;
  localparam logic [7:0] OFS_CUR_ERR_L   = 8'h3C;
  localparam logic [7:0] OFS_CUR_ERR_H   = 8'h3D;
  localparam logic [7:0] OFS_CFG_CHECKS  = 8'h30;

  // ==========================================================================
  // Field positions
  localparam int CTL_ENABLE_BIT   = 7;
  localparam int CTL_ARM_BIT      = 6;
  localparam int CTL_CLR_STKY_BIT = 5;
  localparam int CTL_CLR_LAST_BIT = 4;
  localparam int LAST_UNDER_BIT   = 7;
  localparam int LAST_OVER_BIT    = 6;
  localparam int CHK_SUBCLASS_BIT = 1;
  localparam int CHK_INTERP_BIT   = 0;
  localparam int STS_BUSY_BIT     = 7;
  localparam int STS_LOCK_BIT     = 3;
  localparam int STS_ROTATE_BIT   = 2;
  localparam int STS_WLIM_BIT     = 1;
  localparam int STS_TRIP_BIT     = 0;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] ERR_ZERO   = 4'h0;

  // ==========================================================================
  // Modes, interpolation factors, subclasses
  typedef enum logic [3:0] {
    MODE_ONE_SHOT     = 4'h1,
    MODE_CONTINUOUS   = 4'h2,
    MODE_MONITOR      = 4'h8,
    MODE_ONE_SHOT_MON = 4'h9
  } align_mode_t;

  localparam logic [3:0] INTERP_X1 = 4'h1;
  localparam logic [3:0] INTERP_X2 = 4'h2;
  localparam logic [3:0] INTERP_X4 = 4'h4;
  localparam logic [3:0] INTERP_X8 = 4'h8;
  localparam logic [2:0] SUBCLASS_MAX = 3'h1;

  // ==========================================================================
  // Register-port bundles
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } reg_rsp_t;

endpackage : lmfc_align_pkg

// File: core/lmfc_sysref_sync_control.sv
// Frame-clock alignment against the sampled SYSREF, with its registers
`timescale 1ns/100ps
module lmfc_sysref_sync_control
  import lmfc_align_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire lmfc_align_pkg::reg_req_t reg_req,
  output      lmfc_align_pkg::reg_rsp_t reg_rsp,
  input  wire logic                     sysref_pin,
  input  wire logic [3:0]               lmfc_phase,
  input  wire logic [3:0]               align_mode_select,
  input  wire logic [2:0]               subclass_cfg,
  input  wire logic [3:0]               interp_cfg,
  output      logic                     lmfc_rotate,
  output      logic [3:0]               lmfc_rotate_err
);
  import lmfc_align_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic interp_bad(input logic [3:0] f);
    interp_bad = !(f == INTERP_X1 || f == INTERP_X2 ||
                   f == INTERP_X4 || f == INTERP_X8);
  endfunction : interp_bad

  function automatic logic mode_adjusts(input logic [3:0] m);
    mode_adjusts = (m == MODE_ONE_SHOT) || (m == MODE_CONTINUOUS) ||
                   (m == MODE_ONE_SHOT_MON);
  endfunction : mode_adjusts

  // ==========================================================================
  // SYSREF synchroniser and edge detect
  logic sysref_meta_r, sysref_sync_r, sysref_prev_r;
  logic sysref_meta_nxt, sysref_sync_nxt, sysref_prev_nxt;
  logic sysref_edge;

  always_comb begin
    sysref_meta_nxt = sysref_pin;
    sysref_sync_nxt = sysref_meta_r;
    sysref_prev_nxt = sysref_sync_r;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sysref_meta_r <= 1'b0;
      sysref_sync_r <= 1'b0;
      sysref_prev_r <= 1'b0;
    end else begin
      sysref_meta_r <= sysref_meta_nxt;
      sysref_sync_r <= sysref_sync_nxt;
      sysref_prev_r <= sysref_prev_nxt;
    end
  end

  assign sysref_edge = sysref_sync_r && !sysref_prev_r;

  // ==========================================================================
  // Registers and alignment state
  logic [1:0] window_r,    window_nxt;
  logic [7:0] ctrl_r,      ctrl_nxt;
  logic [3:0] last_err_r,  last_err_nxt;
  logic       last_under_r, last_under_nxt;
  logic       last_over_r,  last_over_nxt;
  logic [3:0] cur_err_r,   cur_err_nxt;
  logic       cur_under_r, cur_under_nxt;
  logic       cur_over_r,  cur_over_nxt;
  logic       rotated_r,   rotated_nxt;
  logic       tripped_r,   tripped_nxt;
  logic       wlim_r,      wlim_nxt;
  logic       lock_r,      lock_nxt;
  logic       oneshot_done_r, oneshot_done_nxt;
  logic [1:0] checks_r,    checks_nxt;
  logic       rotate_r,    rotate_nxt;
  logic [3:0] rot_err_r,   rot_err_nxt;
  reg_rsp_t   rsp_r,       rsp_nxt;

  logic        wr_ctrl;
  logic [7:0]  ctrl_new;
  logic        clr_stky, clr_last;
  logic        armed_hit, do_adjust, outside;
  logic        below, above;
  logic signed [4:0] err_s, win_s;

  always_comb begin
    wr_ctrl  = reg_req.wr_en && (reg_req.addr == OFS_SYNC_CTRL);
    ctrl_new = wr_ctrl ? reg_req.wdata : ctrl_r;
    // Edges taken from the write itself so one write is enough
    clr_stky = ctrl_new[CTL_CLR_STKY_BIT] && !ctrl_r[CTL_CLR_STKY_BIT];
    clr_last = ctrl_new[CTL_CLR_LAST_BIT] && !ctrl_r[CTL_CLR_LAST_BIT];

    err_s   = {lmfc_phase[3], lmfc_phase};
    win_s   = {3'b000, window_r};
    below   = err_s < -win_s;
    above   = err_s > win_s;
    outside = below || above;
  end

  // ==========================================================================
  // One-shot arming and adjust decision
  always_comb begin
    armed_hit = ctrl_r[CTL_ENABLE_BIT] && ctrl_r[CTL_ARM_BIT] &&
                sysref_edge;
    do_adjust = 1'b0;
    oneshot_done_nxt = oneshot_done_r;
    if (ctrl_r[CTL_ENABLE_BIT] && sysref_edge && outside &&
        mode_adjusts(align_mode_select)) begin
      case (align_mode_select)
        MODE_CONTINUOUS: do_adjust = 1'b1;
        MODE_ONE_SHOT,
        MODE_ONE_SHOT_MON: do_adjust = armed_hit && !oneshot_done_r;
        default: do_adjust = 1'b0;
      endcase
    end
    if (armed_hit && align_mode_select != MODE_CONTINUOUS)
      oneshot_done_nxt = 1'b1;
    if (wr_ctrl && reg_req.wdata[CTL_ARM_BIT])
      oneshot_done_nxt = 1'b0;
    if (!ctrl_r[CTL_ENABLE_BIT])
      oneshot_done_nxt = 1'b0;
  end

  // ==========================================================================
  // Host-written registers
  always_comb begin
    window_nxt = window_r;
    if (reg_req.wr_en && reg_req.addr == OFS_ERR_WINDOW)
      window_nxt = reg_req.wdata[1:0];
    ctrl_nxt = ctrl_new;
  end

  // ==========================================================================
  // Current error and lock status
  always_comb begin
    // Current error tracks every SYSREF while enabled, zeroed on adjustment
    cur_err_nxt   = cur_err_r;
    cur_under_nxt = cur_under_r;
    cur_over_nxt  = cur_over_r;
    wlim_nxt      = wlim_r;
    lock_nxt      = lock_r;
    if (ctrl_r[CTL_ENABLE_BIT] && sysref_edge) begin
      cur_err_nxt   = do_adjust ? ERR_ZERO : lmfc_phase;
      cur_under_nxt = do_adjust ? 1'b0 : below;
      cur_over_nxt  = do_adjust ? 1'b0 : above;
      wlim_nxt      = outside;
      lock_nxt      = !outside || do_adjust;
    end
  end

  // ==========================================================================
  // Last recorded error
  always_comb begin
    // Hardware set beats software clear
    last_err_nxt   = clr_last ? ERR_ZERO : last_err_r;
    last_under_nxt = clr_last ? 1'b0 : last_under_r;
    last_over_nxt  = clr_last ? 1'b0 : last_over_r;
    if (do_adjust) begin
      last_err_nxt   = lmfc_phase;
      last_under_nxt = below;
      last_over_nxt  = above;
    end
  end

  // ==========================================================================
  // Sticky status
  always_comb begin
    rotated_nxt = (rotated_r && !clr_stky) || do_adjust;
    tripped_nxt = (tripped_r && !clr_stky) || armed_hit;
  end

  // ==========================================================================
  // Configuration checks
  always_comb begin
    checks_nxt[CHK_SUBCLASS_BIT] = subclass_cfg > SUBCLASS_MAX;
    checks_nxt[CHK_INTERP_BIT]   = interp_bad(interp_cfg);
  end

  // ==========================================================================
  // Frame-clock adjust outputs
  always_comb begin
    rotate_nxt  = do_adjust;
    rot_err_nxt = do_adjust ? lmfc_phase : rot_err_r;
  end

  // ==========================================================================
  // Register read answer
  always_comb begin
    rsp_nxt.valid = reg_req.rd_en;
    rsp_nxt.rdata = RESET_BYTE;
    if (reg_req.rd_en) begin
      case (reg_req.addr)
        OFS_ERR_WINDOW: rsp_nxt.rdata = {6'h00, window_r};
        OFS_LAST_ERR_L: rsp_nxt.rdata = {4'h0, last_err_r};
        OFS_LAST_ERR_H: rsp_nxt.rdata = {last_under_r, last_over_r, 6'h00};
        OFS_SYNC_CTRL:  rsp_nxt.rdata = ctrl_r;
        OFS_SYNC_STATUS:
          rsp_nxt.rdata = {!lock_r && ctrl_r[CTL_ENABLE_BIT], 3'h0,
                           lock_r, rotated_r, wlim_r, tripped_r};
        OFS_CUR_ERR_L:  rsp_nxt.rdata = {4'h0, cur_err_r};
        OFS_CUR_ERR_H:  rsp_nxt.rdata = {cur_under_r, cur_over_r, 6'h00};
        OFS_CFG_CHECKS: rsp_nxt.rdata = {6'h00, checks_r};
        default:        rsp_nxt.rdata = RESET_BYTE;
      endcase
    end
  end

  // ==========================================================================
  // State registers, one block per group
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      window_r <= 2'b00;
      ctrl_r   <= RESET_BYTE;
    end else begin
      window_r <= window_nxt;
      ctrl_r   <= ctrl_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      oneshot_done_r <= 1'b0;
    end else begin
      oneshot_done_r <= oneshot_done_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cur_err_r   <= ERR_ZERO;
      cur_under_r <= 1'b0;
      cur_over_r  <= 1'b0;
      wlim_r      <= 1'b0;
      lock_r      <= 1'b0;
    end else begin
      cur_err_r   <= cur_err_nxt;
      cur_under_r <= cur_under_nxt;
      cur_over_r  <= cur_over_nxt;
      wlim_r      <= wlim_nxt;
      lock_r      <= lock_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      last_err_r   <= ERR_ZERO;
      last_under_r <= 1'b0;
      last_over_r  <= 1'b0;
    end else begin
      last_err_r   <= last_err_nxt;
      last_under_r <= last_under_nxt;
      last_over_r  <= last_over_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rotated_r <= 1'b0;
      tripped_r <= 1'b0;
    end else begin
      rotated_r <= rotated_nxt;
      tripped_r <= tripped_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      checks_r <= 2'b00;
    end else begin
      checks_r <= checks_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rotate_r  <= 1'b0;
      rot_err_r <= ERR_ZERO;
    end else begin
      rotate_r  <= rotate_nxt;
      rot_err_r <= rot_err_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  assign reg_rsp         = rsp_r;
  assign lmfc_rotate     = rotate_r;
  assign lmfc_rotate_err = rot_err_r;

endmodule : lmfc_sysref_sync_control

// File: verification/lmfc_align_assertions.sv
// Port-level checker for the frame-clock alignment block
`timescale 1ns/100ps
module lmfc_align_checker
  import lmfc_align_pkg::*;
(
  input wire logic                     ref_clk,
  input wire logic                     srst,
  input wire lmfc_align_pkg::reg_req_t reg_req,
  input wire lmfc_align_pkg::reg_rsp_t reg_rsp,
  input wire logic                     sysref_pin,
  input wire logic [3:0]               lmfc_phase,
  input wire logic [3:0]               align_mode_select,
  input wire logic [2:0]               subclass_cfg,
  input wire logic [3:0]               interp_cfg,
  input wire logic                     lmfc_rotate,
  input wire logic [3:0]               lmfc_rotate_err
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // Shadows of host writes
  logic       en_r, en_nxt;
  logic [1:0] win_r, win_nxt;
  logic [3:0] w4;
  wire        wr_ctl = reg_req.wr_en && reg_req.addr == OFS_SYNC_CTRL;
  wire        wr_win = reg_req.wr_en && reg_req.addr == OFS_ERR_WINDOW;
  assign w4 = {2'b00, win_r};
  always_comb begin
    en_nxt  = wr_ctl ? reg_req.wdata[7] : en_r;
    win_nxt = wr_win ? reg_req.wdata[1:0] : win_r;
  end
  always_ff @(posedge ref_clk) begin
    en_r  <= srst ? 1'b0 : en_nxt;
    win_r <= srst ? 2'h0 : win_nxt;
  end
  // ==========================================================
  // Properties
  sequence s_adjust;
    lmfc_rotate;
  endsequence
  sequence s_read(logic [7:0] a);
    reg_req.rd_en && reg_req.addr == a;
  endsequence
  property p_rsp_next;
    reg_req.rd_en |=> reg_rsp.valid;
  endproperty
  a_rsp_next: assert property (p_rsp_next)
    else $error("read not answered");
  property p_rsp_cause;
    reg_rsp.valid |-> $past(reg_req.rd_en);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause)
    else $error("answer without read");
  property p_pulse;
    s_adjust |=> !lmfc_rotate;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("adjust pulse too long");
  property p_err;
    s_adjust |-> lmfc_rotate_err == $past(lmfc_phase);
  endproperty
  a_err: assert property (p_err)
    else $error("wrong recorded error");
  property p_en;
    s_adjust |-> en_r && $past(sysref_pin, 3);
  endproperty
  a_en: assert property (p_en)
    else $error("adjust while off or without sysref");
  property p_mode;
    s_adjust |-> $past(align_mode_select) inside
      {MODE_ONE_SHOT, MODE_CONTINUOUS, MODE_ONE_SHOT_MON};
  endproperty
  a_mode: assert property (p_mode)
    else $error("adjust in a non-adjusting mode");
  property p_win;
    s_adjust |-> $signed(lmfc_rotate_err) > $signed(w4) ||
      $signed(lmfc_rotate_err) < -$signed(w4);
  endproperty
  a_win: assert property (p_win)
    else $error("adjust inside window");
  property p_chk;
    s_read(OFS_CFG_CHECKS) |=> reg_rsp.rdata == {6'h00,
      $past(subclass_cfg, 2) > 3'h1,
      !($past(interp_cfg, 2) inside {4'h1, 4'h2, 4'h4, 4'h8})};
  endproperty
  a_chk: assert property (p_chk)
    else $error("configuration flags wrong");
  property p_winrd;
    s_read(OFS_ERR_WINDOW) |=> reg_rsp.rdata == {6'h00, win_r};
  endproperty
  a_winrd: assert property (p_winrd)
    else $error("window readback wrong");
endmodule : lmfc_align_checker
bind lmfc_sysref_sync_control lmfc_align_checker i_lmfc_align_checker (
  .ref_clk(ref_clk), .srst(srst), .reg_req(reg_req), .reg_rsp(reg_rsp),
  .sysref_pin(sysref_pin), .lmfc_phase(lmfc_phase),
  .align_mode_select(align_mode_select), .subclass_cfg(subclass_cfg),
  .interp_cfg(interp_cfg), .lmfc_rotate(lmfc_rotate),
  .lmfc_rotate_err(lmfc_rotate_err));

// File: verification/sysref_source.sv
// SYSREF source model: one pulse per request with a set phase error
`timescale 1ns/100ps
module sysref_source (
  input  wire logic       ref_clk,
  input  wire logic       fire,
  input  wire logic [3:0] phase_err,
  output      logic       sysref_pin,
  output      logic [3:0] lmfc_phase
);
  logic [2:0] hold_r = 3'h0;
  logic [3:0] junk_r = 4'h5;
  always @(posedge ref_clk) begin
    junk_r <= ~junk_r + 4'h3;
    hold_r <= fire ? 3'h5 : (hold_r != 3'h0 ? hold_r - 3'h1 : 3'h0);
  end
  // Phase is garbage outside a pulse, so stale values cannot pass
  assign sysref_pin = hold_r != 3'h0;
  assign lmfc_phase = sysref_pin ? phase_err : junk_r;
endmodule : sysref_source

// File: verification/lmfc_sysref_sync_control_test.sv
// Self-checking bench for the frame-clock alignment block
`timescale 1ns/100ps
module lmfc_sysref_sync_control_test;
  import lmfc_align_pkg::*;
  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  reg_req_t   req = '0;
  reg_rsp_t   rsp;
  logic       fire = 1'b0, pin, rot;
  logic [3:0] perr = 4'h0, mode = 4'h2, intp = 4'h4, ph, rerr;
  logic [2:0] subc = 3'h1;
  int         error_cnt = 0, comparisons = 0, cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  lmfc_sysref_sync_control i_lmfc_sysref_sync_control (.ref_clk(ref_clk),
    .srst(srst), .reg_req(req), .reg_rsp(rsp), .sysref_pin(pin),
    .lmfc_phase(ph), .align_mode_select(mode), .subclass_cfg(subc),
    .interp_cfg(intp), .lmfc_rotate(rot), .lmfc_rotate_err(rerr));
  sysref_source i_sysref_source (.ref_clk(ref_clk), .fire(fire),
    .phase_err(perr), .sysref_pin(pin), .lmfc_phase(ph));
  // ==========================================================
  // Bus and compare tasks
  task automatic cmp(string w, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask : cmp
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    req <= '0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] m = 8'hFF);
    @(posedge ref_clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    req <= '0;
    // Answer stands one cycle only, so look just after its edge
    #1 cmp($sformatf("reg %h", a), e, rsp.valid ? rsp.rdata & m : 8'hxx);
    @(posedge ref_clk);
  endtask : rd
  task automatic pulse(logic [3:0] e, logic [7:0] n_exp);
    logic [7:0] n;
    n = 8'h00;
    @(posedge ref_clk);
    perr <= e;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (12) begin
      @(posedge ref_clk);
      #1 if (rot === 1'b1) n++;
    end
    cmp("adjust count", n_exp, n);
    if (n_exp != 8'h00) cmp("adjust error", {4'h0, e}, {4'h0, rerr});
    @(posedge ref_clk);
  endtask : pulse
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd(OFS_SYNC_CTRL, 8'h00);
    rd(OFS_LAST_ERR_H, 8'h00);
    rd(OFS_SYNC_STATUS, 8'h00);
    rd(8'h50, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_checks;
    logic [3:0] f[6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h0};
    for (int s = 0; s < 4; s++) begin
      foreach (f[i]) begin
        subc <= 3'(s);
        intp <= f[i];
        rd(OFS_CFG_CHECKS, {6'h00, s > 1, i > 3});
      end
    end
    subc <= 3'h1;
    intp <= 4'h4;
    $display("test checks done");
  endtask : t_checks
  task automatic t_window;
    wr(OFS_ERR_WINDOW, 8'hFD);
    rd(OFS_ERR_WINDOW, 8'h01);
    wr(OFS_SYNC_CTRL, 8'h80);
    pulse(4'h1, 8'h00);
    pulse(4'hF, 8'h00);
    rd(OFS_CUR_ERR_L, 8'h0F);
    pulse(4'h2, 8'h01);
    rd(OFS_LAST_ERR_L, 8'h02);
    rd(OFS_LAST_ERR_H, 8'h40);
    pulse(4'hE, 8'h01);
    rd(OFS_LAST_ERR_H, 8'h80);
    rd(OFS_CUR_ERR_L, 8'h00);
    rd(OFS_SYNC_STATUS, 8'h04, 8'h05);
    $display("test window done");
  endtask : t_window
  task automatic t_clear;
    wr(OFS_SYNC_CTRL, 8'hC0);
    pulse(4'h3, 8'h01);
    rd(OFS_SYNC_STATUS, 8'h05, 8'h05);
    wr(OFS_SYNC_CTRL, 8'hE0);
    rd(OFS_SYNC_STATUS, 8'h00, 8'h05);
    rd(OFS_LAST_ERR_L, 8'h03);
    wr(OFS_SYNC_CTRL, 8'hD0);
    rd(OFS_LAST_ERR_L, 8'h00);
    rd(OFS_LAST_ERR_H, 8'h00);
    $display("test clear done");
  endtask : t_clear
  task automatic t_modes;
    wr(OFS_ERR_WINDOW, 8'h00);
    mode <= 4'h8;
    wr(OFS_SYNC_CTRL, 8'hC0);
    pulse(4'h3, 8'h00);
    mode <= 4'h2;
    wr(OFS_SYNC_CTRL, 8'h40);
    pulse(4'h3, 8'h00);
    mode <= 4'h1;
    wr(OFS_SYNC_CTRL, 8'hC0);
    pulse(4'h3, 8'h01);
    pulse(4'h3, 8'h00);
    wr(OFS_SYNC_CTRL, 8'hC0);
    pulse(4'hD, 8'h01);
    mode <= 4'h9;
    wr(OFS_SYNC_CTRL, 8'hC0);
    pulse(4'h2, 8'h01);
    pulse(4'h2, 8'h00);
    $display("test modes done");
  endtask : t_modes
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_checks();
    t_window();
    t_clear();
    t_modes();
    print_verdict();
  end
endmodule : lmfc_sysref_sync_control_test
